// ### spc_pkg.sv
package spc_pkg;

  // Word lengths, expressed as the last bit index of a word.
  localparam logic [3:0] LAST10    = 4'h9;
  localparam logic [3:0] LAST8     = 4'h7;
  // Bit index that follows the seventh bit of a comma.
  localparam logic [3:0] COMMA_IDX = 4'h7;
  localparam logic [3:0] CNT_RST   = 4'h0;
  localparam logic [6:0] COMMA_POS = 7'h1F;
  localparam logic [6:0] COMMA_NEG = 7'h60;
  localparam logic [7:0] SKIP_BYTE = 8'h1C;
  localparam logic [7:0] IDLE_BYTE = 8'hBC;
  localparam logic [4:0] K28       = 5'h1C;
  localparam logic [5:0] K28_6B    = 6'h0F;
  localparam logic [3:0] ALT7_4B   = 4'h7;
  localparam logic [9:0] RAW_IDLE  = 10'h000;
  localparam logic       RD_RST    = 1'b0;
  localparam int         FIFO_DEPTH = 16;

  // Six-bit sub-blocks for negative running disparity, index is the 5-bit value.
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  // Four-bit sub-blocks for negative running disparity, index is the 3-bit value.
  localparam logic [3:0] T4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  typedef struct packed {
    logic       bypass;
    logic       halfRate;
    logic       rxInvert;
    logic       txInvert;
    logic       eightBit;
    logic       alignEn;
    logic [4:0] skipLow;
    logic [4:0] skipHigh;
  } spc_cfg_t;

  typedef struct packed {
    logic       k;
    logic       codeErr;
    logic       dispErr;
    logic [9:0] data;
  } spc_sym_t;

  typedef struct packed {
    logic [1:0]  k;
    logic [19:0] data;
  } spc_tx_t;

  typedef struct packed {
    logic [1:0]  k;
    logic [1:0]  codeErr;
    logic [1:0]  dispErr;
    logic [19:0] data;
  } spc_rx_t;

endpackage

// ### spc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module spc_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = spc_pkg::FIFO_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   wrValid,
  output logic                        wrReady,
  input  wire logic [W-1:0]           wrData,
  output logic                        rdValid,
  input  wire logic                   rdReady,
  output logic [W-1:0]                rdData,
  output logic [$clog2(DEPTH):0]      level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_r, wp_nxt;
  logic [AW:0]  rp_r, rp_nxt;
  logic [AW:0]  memCnt;
  logic         oV_r, oV_nxt;
  logic [W-1:0] oD_r, oD_nxt;
  logic         push;
  logic         pop;

  //////////////////////////////////////////////////////////////////////////////
  // Pointer and output-register next state; the read data always come from oD_r.
  always_comb begin
    memCnt  = wp_r - rp_r;
    wrReady = (memCnt != (AW+1)'(DEPTH));
    push    = wrValid && wrReady;
    pop     = (memCnt != '0) && (!oV_r || rdReady);
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    oV_nxt  = oV_r && !rdReady;
    oD_nxt  = oD_r;
    if (pop) begin
      oV_nxt = 1'b1;
      oD_nxt = mem[rp_r[AW-1:0]];
    end
    level   = memCnt + {{AW{1'b0}}, oV_r};
    rdValid = oV_r;
    rdData  = oD_r;
  end

  // Storage has no reset; only the pointers, the valid flag and oD_r get one.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      oV_r <= 1'b0;
      oD_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      oV_r <= oV_nxt;
      oD_r <= oD_nxt;
    end
  end

endmodule
`default_nettype wire

// ### spc_channel.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Recover serial bits, deserialize into 8/10-bit words.
// - Serialize 8/10-bit words onto transmit line.
// - Provide receive and transmit word clocks.
// - Receive order: polarity, align, decode, compensation.
// - Receive words cross to core through FIFO.
// - Transmit: encode, then polarity, then serialize.
// - Bypass passes raw words without coding.
// - Half rate pairs two words per transfer.
// - Bit slip shifts word boundary one bit.
module spc_channel #(
  parameter int DEPTH = spc_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire spc_pkg::spc_cfg_t cfg,
  input  wire logic              rxSerial,
  input  wire logic              rxSlip,
  input  wire logic              rxReady,
  output var  spc_pkg::spc_rx_t  rxOut,
  output logic                   rxValid,
  output logic                   rxAligned,
  output logic                   rxOverflow,
  output logic                   rxWordTick,
  input  wire spc_pkg::spc_tx_t  txIn,
  input  wire logic              txValid,
  output logic                   txReady,
  output logic                   txSerial,
  output logic                   txWordTick
);
  localparam int LVW = $clog2(DEPTH) + 1;
  localparam int SW  = $bits(spc_pkg::spc_sym_t);

  // Returns {rd, code}; only K28.y control symbols are encodable.
  function automatic logic [10:0] spcEnc(input logic [7:0] d, input logic k,
                                         input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic       r;
    logic       alt;
    s6 = k ? spc_pkg::K28_6B : spc_pkg::T6[d[4:0]];
    r  = rd;
    if ($countones(s6) != 3 || d[4:0] == 5'h07) begin
      if (r) s6 = ~s6;
      if ($countones(s6) != 3) r = ~r;
    end
    alt = (d[7:5] == 3'h7) && (k || (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12
          || d[4:0] == 5'h14)) || (r && (d[4:0] == 5'h0B || d[4:0] == 5'h0D
          || d[4:0] == 5'h0E)));
    s4 = alt ? spc_pkg::ALT7_4B : spc_pkg::T4[d[7:5]];
    if ($countones(s4) != 2 || d[7:5] == 3'h3) begin
      if (r) s4 = ~s4;
      if ($countones(s4) != 2) r = ~r;
    end else if (k && !r) begin
      s4 = ~s4;
    end
    return {r, s6, s4};
  endfunction

  // Returns {rd, k, codeErr, dispErr, byte}.
  function automatic logic [11:0] spcDec(input logic [9:0] c, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic [3:0] cand;
    logic [4:0] x;
    logic [2:0] y;
    logic       h6;
    logic       h4;
    logic       k;
    logic       r6;
    logic       de;
    int         n6;
    int         n4;
    s6 = c[9:4];
    s4 = c[3:0];
    x  = '0;
    y  = '0;
    h6 = 1'b0;
    h4 = 1'b0;
    n6 = $countones(s6);
    n4 = $countones(s4);
    for (int i = 0; i < 32; i++) begin
      if (s6 == spc_pkg::T6[i] || (s6 == ~spc_pkg::T6[i]
          && ($countones(spc_pkg::T6[i]) != 3 || i == 7))) begin
        x  = 5'(i);
        h6 = 1'b1;
      end
    end
    k = (s6 == spc_pkg::K28_6B) || (s6 == ~spc_pkg::K28_6B);
    if (k) begin
      x  = spc_pkg::K28;
      h6 = 1'b1;
    end
    de = (n6 > 3 && rd) || (n6 < 3 && !rd);
    r6 = (n6 == 3) ? rd : (n6 > 3);
    for (int j = 0; j < 8; j++) begin
      cand = spc_pkg::T4[j];
      if (($countones(cand) != 2 || j == 3) && r6) cand = ~cand;
      if (k && $countones(cand) == 2 && j != 3 && !r6) cand = ~cand;
      if (s4 == cand) begin
        y  = 3'(j);
        h4 = 1'b1;
      end
    end
    if (s4 == (r6 ? ~spc_pkg::ALT7_4B : spc_pkg::ALT7_4B)) begin
      y  = 3'h7;
      h4 = 1'b1;
    end
    de = de || (n4 > 2 && r6) || (n4 < 2 && !r6);
    return {((n4 == 2) ? r6 : (n4 > 2)), k, !(h6 && h4), de, y, x};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Receive deserializer, polarity select and comma alignment.
  logic [3:0] rxCnt_r, rxCnt_nxt;
  logic [9:0] rxSh_r, rxSh_nxt;
  logic [9:0] rxWord_r, rxWord_nxt;
  logic       rxWordVal_r, rxAligned_r, rxAligned_nxt;
  logic       rxLast, comma, rxStb;

  // Equalization and clock recovery sit in the analog front end; bits arrive one per clk.
  always_comb begin
    rxSh_nxt      = {rxSh_r[8:0], rxSerial ^ cfg.rxInvert};
    rxLast        = rxCnt_r == (cfg.eightBit ? spc_pkg::LAST8 : spc_pkg::LAST10);
    comma         = cfg.alignEn && !cfg.eightBit && (rxSh_nxt[6:0] == spc_pkg::COMMA_POS
                    || rxSh_nxt[6:0] == spc_pkg::COMMA_NEG);
    rxStb         = rxLast && !comma && !rxSlip;
    rxCnt_nxt     = comma ? spc_pkg::COMMA_IDX : rxSlip ? rxCnt_r :
                    rxLast ? spc_pkg::CNT_RST : rxCnt_r + 4'h1;
    rxAligned_nxt = comma || (rxAligned_r && !rxSlip);
    rxWord_nxt    = rxWord_r;
    if (rxStb) begin
      rxWord_nxt = cfg.eightBit ? {2'b00, rxSh_nxt[7:0]} : rxSh_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxCnt_r     <= spc_pkg::CNT_RST;
      rxSh_r      <= '0;
      rxWord_r    <= '0;
      rxWordVal_r <= 1'b0;
      rxAligned_r <= 1'b0;
    end else begin
      rxCnt_r     <= rxCnt_nxt;
      rxSh_r      <= rxSh_nxt;
      rxWord_r    <= rxWord_nxt;
      rxWordVal_r <= rxStb;
      rxAligned_r <= rxAligned_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode stage with running disparity; bypass and 8-bit words pass untouched.
  spc_pkg::spc_sym_t sym_r, sym_nxt;
  logic              symVal_r;
  logic              rxRd_r, rxRd_nxt;
  logic [11:0]       dec;

  always_comb begin
    dec      = spcDec(rxWord_r, rxRd_r);
    sym_nxt  = sym_r;
    rxRd_nxt = rxRd_r;
    if (rxWordVal_r) begin
      if (cfg.bypass || cfg.eightBit) begin
        sym_nxt = '{k: 1'b0, codeErr: 1'b0, dispErr: 1'b0, data: rxWord_r};
      end else begin
        sym_nxt  = '{k: dec[10], codeErr: dec[9], dispErr: dec[8],
                     data: {2'b00, dec[7:0]}};
        rxRd_nxt = dec[11];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sym_r    <= '0;
      symVal_r <= 1'b0;
      rxRd_r   <= spc_pkg::RD_RST;
    end else begin
      sym_r    <= sym_nxt;
      symVal_r <= rxWordVal_r;
      rxRd_r   <= rxRd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock tolerance compensation in front of the FIFO.
  logic               isSkip, dropSkip, fifoWrValid, fifoWrReady;
  logic               insert_r, insert_nxt, rxOvf_r, rxOvf_nxt;
  spc_pkg::spc_sym_t  fifoWrData, fifoRdData;
  logic               fifoRdValid, fifoRdReady;
  logic [LVW-1:0]     level;

  // The serial line cannot be stalled, so a write the FIFO refuses is lost and latched.
  always_comb begin
    isSkip      = symVal_r && sym_r.k && !cfg.bypass && sym_r.data[7:0] == spc_pkg::SKIP_BYTE;
    dropSkip    = isSkip && (level >= LVW'(cfg.skipHigh));
    insert_nxt  = isSkip && !dropSkip && (level < LVW'(cfg.skipLow));
    fifoWrValid = (symVal_r && !dropSkip) || insert_r;
    fifoWrData  = sym_r; // A duplicated skip is simply the held symbol again.
    rxOvf_nxt   = rxOvf_r || (fifoWrValid && !fifoWrReady);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      insert_r <= 1'b0;
      rxOvf_r  <= 1'b0;
    end else begin
      insert_r <= insert_nxt;
      rxOvf_r  <= rxOvf_nxt;
    end
  end

  spc_fifo #(.W(SW), .DEPTH(DEPTH)) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wrValid (fifoWrValid),
    .wrReady (fifoWrReady),
    .wrData  (fifoWrData),
    .rdValid (fifoRdValid),
    .rdReady (fifoRdReady),
    .rdData  (fifoRdData),
    .level   (level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Core-side output register, pairing two words in half-rate mode.
  spc_pkg::spc_rx_t out_r, out_nxt;
  logic             outV_r, outV_nxt, lane_r, lane_nxt;

  always_comb begin
    fifoRdReady = !outV_r || rxReady;
    out_nxt     = out_r;
    outV_nxt    = outV_r && !rxReady;
    lane_nxt    = lane_r;
    if (fifoRdValid && fifoRdReady) begin
      if (cfg.halfRate && lane_r) begin
        out_nxt.data[19:10] = fifoRdData.data;
        out_nxt.k[1]        = fifoRdData.k;
        out_nxt.codeErr[1]  = fifoRdData.codeErr;
        out_nxt.dispErr[1]  = fifoRdData.dispErr;
        outV_nxt            = 1'b1;
        lane_nxt            = 1'b0;
      end else begin
        out_nxt            = '0;
        out_nxt.data[9:0]  = fifoRdData.data;
        out_nxt.k[0]       = fifoRdData.k;
        out_nxt.codeErr[0] = fifoRdData.codeErr;
        out_nxt.dispErr[0] = fifoRdData.dispErr;
        outV_nxt           = !cfg.halfRate;
        lane_nxt           = cfg.halfRate;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_r  <= '0;
      outV_r <= 1'b0;
      lane_r <= 1'b0;
    end else begin
      out_r  <= out_nxt;
      outV_r <= outV_nxt;
      lane_r <= lane_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit path: hold register, encoder, polarity, serializer.
  spc_pkg::spc_tx_t hold_r, hold_nxt;
  logic             holdV_r, holdV_nxt, txLane_r, txLane_nxt, txRd_r, txRd_nxt;
  logic [3:0]       txCnt_r, txCnt_nxt;
  logic [9:0]       txSh_r, txSh_nxt, raw, word;
  logic [10:0]      enc;
  logic             txLast, txRdy_r, txTick_r, kSel, accept;

  // With nothing held the coded line carries idle commas so the far end stays aligned; bypass sends RAW_IDLE, 8-bit mode the raw idle byte.
  always_comb begin
    txLast     = txCnt_r == (cfg.eightBit ? spc_pkg::LAST8 : spc_pkg::LAST10);
    txCnt_nxt  = txLast ? spc_pkg::CNT_RST : txCnt_r + 4'h1;
    txSh_nxt   = {txSh_r[8:0], 1'b0};
    accept     = txValid && txRdy_r;
    hold_nxt   = accept ? txIn : hold_r;
    holdV_nxt  = holdV_r || accept;
    txLane_nxt = txLane_r;
    txRd_nxt   = txRd_r;
    raw        = txLane_r ? hold_r.data[19:10] : hold_r.data[9:0];
    kSel       = txLane_r ? hold_r.k[1] : hold_r.k[0];
    if (!holdV_r) begin
      raw  = cfg.bypass ? spc_pkg::RAW_IDLE : {2'b00, spc_pkg::IDLE_BYTE};
      kSel = 1'b1;
    end
    enc  = spcEnc(raw[7:0], kSel, txRd_r);
    word = ((cfg.bypass || cfg.eightBit) ? raw : enc[9:0]) ^ {10{cfg.txInvert}};
    if (txLast) begin
      txSh_nxt = cfg.eightBit ? {word[7:0], 2'b00} : word;
      if (!(cfg.bypass || cfg.eightBit)) txRd_nxt = enc[10];
      if (holdV_r) begin
        txLane_nxt = cfg.halfRate && !txLane_r;
        holdV_nxt  = cfg.halfRate && !txLane_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_r   <= '0;
      holdV_r  <= 1'b0;
      txLane_r <= 1'b0;
      txRd_r   <= spc_pkg::RD_RST;
      txCnt_r  <= spc_pkg::CNT_RST;
      txSh_r   <= '0;
      txRdy_r  <= 1'b0;
      txTick_r <= 1'b0;
    end else begin
      hold_r   <= hold_nxt;
      holdV_r  <= holdV_nxt;
      txLane_r <= txLane_nxt;
      txRd_r   <= txRd_nxt;
      txCnt_r  <= txCnt_nxt;
      txSh_r   <= txSh_nxt;
      txRdy_r  <= !holdV_nxt;
      txTick_r <= txLast;
    end
  end

  assign rxOut      = out_r;
  assign rxValid    = outV_r;
  assign rxAligned  = rxAligned_r;
  assign rxOverflow = rxOvf_r;
  assign rxWordTick = rxWordVal_r;
  assign txReady    = txRdy_r;
  assign txSerial   = txSh_r[9];
  assign txWordTick = txTick_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the channel's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence rxPipe_s;
    rxWordVal_r ##1 symVal_r;
  endsequence

  deser_word_a: assert property (rxStb && !cfg.eightBit |=> rxWord_r == $past(rxSh_nxt))
    else $error("deserialized word does not match shifted bits");
  ser_bit_a: assert property (txLast |=> txSerial == $past(txSh_nxt[9]))
    else $error("first serial bit is not the loaded word MSB");
  tx_tick_a: assert property (txWordTick && !cfg.eightBit
                              |=> !txWordTick [*8] ##1 !txWordTick ##1 txWordTick)
    else $error("transmit word tick period is not ten cycles");
  rx_order_a: assert property (rxStb |=> rxPipe_s)
    else $error("received word did not reach the decode stage");
  fifo_cross_a: assert property ($rose(rxValid) |-> $past(fifoRdValid))
    else $error("output valid without a FIFO word");
  enc_bal_a: assert property (txLast && !cfg.bypass && !cfg.eightBit
                              |=> $countones(txSh_r) inside {[4:6]})
    else $error("encoded word is not balanced");
  bypass_raw_a: assert property (symVal_r && cfg.bypass
                                 |-> sym_r.data == $past(rxWord_r) && !sym_r.codeErr)
    else $error("bypass word altered");
  half_pair_a: assert property (accept && cfg.halfRate |-> ##[1:20] (txLast && txLane_r))
    else $error("second half-rate lane not sent");
  slip_hold_a: assert property (rxSlip && !comma |=> rxCnt_r == $past(rxCnt_r))
    else $error("bit slip did not hold the word counter");
  skip_drop_a: assert property (isSkip && level >= LVW'(cfg.skipHigh) |-> !fifoWrValid)
    else $error("skip written while FIFO above upper bound");
  code_err_a: assert property (rxWordVal_r && !cfg.bypass && !cfg.eightBit
                               && !($countones(rxWord_r) inside {[4:6]}) |=> sym_r.codeErr)
    else $error("unbalanced code not flagged");

endmodule
`default_nettype wire

// ### spc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far-end transceiver. It sends queued code pairs, or commas when its queue is
// empty, and collects the words that arrive on the transmit line.
module spc_far_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic invert,
  input  wire logic txSerial,
  input  wire logic txWordTick,
  output logic      rxSerial
);
  logic [19:0] sendQ [$];
  logic [9:0]  gotQ  [$];
  logic [19:0] pair;
  logic [9:0]  outW;
  logic [9:0]  inW;
  logic        rd;
  int          outIdx;
  int          inIdx;

  // Each entry holds the negative form above the positive form, and the
  // running disparity picks one, so an error is only sent when asked for.
  always @(posedge clk) begin
    if (sys_rst) begin
      rd = 1'b0;
      rxSerial <= 1'b0;
      outIdx = 0;
      inIdx = 0;
      sendQ.delete();
    end else begin
      if (outIdx == 0) begin
        pair = (sendQ.size() > 0) ? sendQ.pop_front() : {10'h0FA, 10'h305};
        outW = rd ? pair[9:0] : pair[19:10];
        if ($countones(outW) != 5) rd = ~rd;
      end
      rxSerial <= outW[9 - outIdx] ^ invert;
      outIdx = (outIdx == 9) ? 0 : outIdx + 1;
      // Framing follows the word tick, so no comma hunt is needed here.
      if (txWordTick) begin
        inW = {9'h000, txSerial};
        inIdx = 1;
      end else if (inIdx > 0) begin
        inW = {inW[8:0], txSerial};
        inIdx++;
      end
      if (inIdx == 10) begin
        gotQ.push_back(inW);
        inIdx = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### spc_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
////////////////////////////////////////////////////////////////////////////////
module spc_channel_tb;
  logic               clk;
  logic               sys_rst;
  spc_pkg::spc_cfg_t  cfg;
  logic               rxSerial;
  logic               rxSlip;
  logic               rxReady;
  spc_pkg::spc_rx_t   rxOut;
  logic               rxValid;
  logic               rxAligned;
  logic               rxOverflow;
  logic               rxWordTick;
  spc_pkg::spc_tx_t   txIn;
  logic               txValid;
  logic               txReady;
  logic               txSerial;
  logic               txWordTick;
  spc_pkg::spc_sym_t  rxQ [$];
  int                 err_total = 0;
  int                 compares = 0;

  spc_channel #(.DEPTH(spc_pkg::FIFO_DEPTH)) uut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
    .rxSerial(rxSerial), .rxSlip(rxSlip), .rxReady(rxReady), .rxOut(rxOut),
    .rxValid(rxValid), .rxAligned(rxAligned), .rxOverflow(rxOverflow),
    .rxWordTick(rxWordTick), .txIn(txIn), .txValid(txValid), .txReady(txReady),
    .txSerial(txSerial), .txWordTick(txWordTick));

  spc_far_model far (.clk(clk), .sys_rst(sys_rst), .invert(cfg.rxInvert),
    .txSerial(txSerial), .txWordTick(txWordTick), .rxSerial(rxSerial));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Idles are dropped on the way in, so scenarios only see what they sent.
  function automatic void keep(input spc_pkg::spc_sym_t s);
    if (!(s.k === 1'b1 && s.data[7:0] === 8'hBC && s.codeErr === 1'b0 && s.dispErr === 1'b0)
        && !(cfg.bypass && (s.data === 10'h0FA || s.data === 10'h305)))
      rxQ.push_back(s);
  endfunction

  // Core-side collector, lane 0 before lane 1.
  always @(posedge clk) begin
    if (!sys_rst && rxValid === 1'b1 && rxReady === 1'b1) begin
      keep({rxOut.k[0], rxOut.codeErr[0], rxOut.dispErr[0], rxOut.data[9:0]});
      if (cfg.halfRate) keep({rxOut.k[1], rxOut.codeErr[1], rxOut.dispErr[1], rxOut.data[19:10]});
    end
  end

  function automatic spc_pkg::spc_cfg_t mk(input logic byp, input logic half, input logic rInv,
                                           input logic tInv, input logic [4:0] lo,
                                           input logic [4:0] hi);
    return '{byp, half, rInv, tInv, 1'b0, 1'b1, lo, hi};
  endfunction

  localparam spc_pkg::spc_cfg_t CODED = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 5'h1F};

  // Configuration only changes under reset, so every scenario starts here.
  task automatic start(input spc_pkg::spc_cfg_t c);
    int i;
    sys_rst <= 1'b1;
    cfg <= c;
    rxReady <= 1'b1;
    txValid <= 1'b0;
    rxSlip <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(txReady, 1'b0)
    sys_rst <= 1'b0;
    for (i = 0; i < 400 && rxAligned !== 1'b1; i++) @(posedge clk);
    `CHK(rxAligned, !c.eightBit)
    repeat (60) @(posedge clk);
    rxQ.delete();
    far.gotQ.delete();
  endtask

  task automatic rpull(output spc_pkg::spc_sym_t s);
    int i;
    for (i = 0; i < 400 && rxQ.size() == 0; i++) @(posedge clk);
    s = (rxQ.size() > 0) ? rxQ.pop_front() : 'x;
  endtask

  task automatic rexp(input logic k, input logic [9:0] d);
    spc_pkg::spc_sym_t s;
    rpull(s);
    `CHK(s, {k, 2'b00, d})
  endtask

  // Skips idle words on the line; a word that never comes reads as the last idle popped, or all ones if none arrived.
  task automatic texp(input logic [9:0] d);
    logic [9:0] w;
    logic       got;
    int         i;
    got = 1'b0;
    w = 10'h3FF;
    for (i = 0; i < 400 && !got; i++) begin
      if (far.gotQ.size() > 0) begin
        w = far.gotQ.pop_front();
        got = !(w inside {10'h0FA, 10'h305, 10'h000});
      end else @(posedge clk);
    end
    `CHK(w, d)
  endtask

  // Holds the request until an edge samples txReady high.
  task automatic tput(input logic [1:0] k, input logic [19:0] d);
    int i;
    txIn <= '{k, d};
    txValid <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 100 && txReady !== 1'b1; i++) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic rx_coded;
    int n;
    start(CODED);
    far.sendQ.push_back({10'h2AA, 10'h2AA});
    far.sendQ.push_back({10'h155, 10'h155});
    far.sendQ.push_back({10'h0F4, 10'h30B});
    rexp(1'b0, 10'h0B5);
    rexp(1'b0, 10'h04A);
    rexp(1'b1, 10'h01C);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      n += rxWordTick;
    end
    `CHK(n, 10)
  endtask

  task automatic rx_errors;
    spc_pkg::spc_sym_t s;
    start(CODED);
    far.sendQ.push_back({10'h305, 10'h0FA});
    rpull(s);
    `CHK(s.dispErr, 1'b1)
    start(CODED);
    far.sendQ.push_back({10'h000, 10'h000});
    rpull(s);
    `CHK(s.codeErr, 1'b1)
  endtask

  task automatic rx_invert;
    start(mk(1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 5'h1F));
    far.sendQ.push_back({10'h2AA, 10'h2AA});
    rexp(1'b0, 10'h0B5);
  endtask

  task automatic rx_slip;
    int i;
    start(CODED);
    rxSlip <= 1'b1;
    @(posedge clk);
    rxSlip <= 1'b0;
    @(posedge clk);
    `CHK(rxAligned, 1'b0)
    for (i = 0; i < 400 && rxAligned !== 1'b1; i++) @(posedge clk);
    `CHK(rxAligned, 1'b1)
    repeat (40) @(posedge clk);
    rxQ.delete();
    far.sendQ.push_back({10'h2AA, 10'h2AA});
    rexp(1'b0, 10'h0B5);
  endtask

  task automatic rx_bypass;
    start(mk(1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 5'h1F));
    far.sendQ.push_back({10'h2AA, 10'h2AA});
    far.sendQ.push_back({10'h155, 10'h155});
    rexp(1'b0, 10'h2AA);
    rexp(1'b0, 10'h155);
  endtask

  task automatic rx_half;
    start(mk(1'b0, 1'b1, 1'b0, 1'b0, 5'h00, 5'h1F));
    far.sendQ.push_back({10'h2AA, 10'h2AA});
    far.sendQ.push_back({10'h155, 10'h155});
    rexp(1'b0, 10'h0B5);
    rexp(1'b0, 10'h04A);
  endtask

  // A nearly empty buffer doubles a lone skip and nothing more.
  task automatic rx_skips;
    start(mk(1'b0, 1'b0, 1'b0, 1'b0, 5'h04, 5'h1F));
    far.sendQ.push_back({10'h0F4, 10'h30B});
    rexp(1'b1, 10'h01C);
    rexp(1'b1, 10'h01C);
    repeat (100) @(posedge clk);
    `CHK(rxQ.size(), 0)
  endtask

  // With the core stalled, skips beyond the high mark are dropped and the
  // buffer eventually refuses words.
  task automatic rx_fill;
    int n;
    start(mk(1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 5'h01));
    rxReady <= 1'b0;
    repeat (3) far.sendQ.push_back({10'h0F4, 10'h30B});
    repeat (300) @(posedge clk);
    `CHK(rxOverflow, 1'b1)
    `CHK(rxValid, 1'b1)
    rxReady <= 1'b1;
    repeat (400) @(posedge clk);
    n = 0;
    foreach (rxQ[j]) n += (rxQ[j].data[7:0] === 8'h1C);
    `CHK(n <= 2, 1'b1)
  endtask

  task automatic tx_coded;
    int n;
    start(CODED);
    tput(2'b00, {10'h000, 10'h0B5});
    tput(2'b00, {10'h000, 10'h04A});
    txValid <= 1'b0;
    texp(10'h2AA);
    texp(10'h155);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      n += txWordTick;
    end
    `CHK(n, 10)
  endtask

  task automatic tx_invert;
    start(mk(1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 5'h1F));
    tput(2'b00, {10'h000, 10'h0B5});
    txValid <= 1'b0;
    texp(10'h155);
  endtask

  task automatic tx_bypass;
    start(mk(1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 5'h1F));
    tput(2'b00, {10'h000, 10'h2C7});
    txValid <= 1'b0;
    texp(10'h2C7);
  endtask

  task automatic tx_half;
    start(mk(1'b0, 1'b1, 1'b0, 1'b0, 5'h00, 5'h1F));
    tput(2'b00, {10'h04A, 10'h0B5});
    txValid <= 1'b0;
    texp(10'h2AA);
    texp(10'h155);
  endtask

  // Eight-bit words skip the coder and the far model frames ten bits, so the
  // bench frames them itself from the word tick.
  task automatic tx_eight;
    logic [7:0] w;
    int         i;
    start('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 5'h1F});
    tput(2'b00, 20'h000A5);
    txValid <= 1'b0;
    w = spc_pkg::IDLE_BYTE;
    for (i = 0; i < 40 && w === spc_pkg::IDLE_BYTE; i++) begin
      @(posedge clk);
      while (txWordTick !== 1'b1) @(posedge clk);
      w = {7'h00, txSerial};
      repeat (7) begin
        @(posedge clk);
        w = {w[6:0], txSerial};
      end
    end
    `CHK(w, 8'hA5)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The whole sequence needs about 3000 cycles; this allows twenty times that.
  initial begin
    #(8 * 60000);
    err_total++;
    complete_run();
  end

  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    cfg = CODED;
    rxSlip = 1'b0;
    rxReady = 1'b0;
    txIn = '0;
    txValid = 1'b0;
    @(posedge clk);
    rx_coded();
    rx_errors();
    rx_invert();
    rx_slip();
    rx_bypass();
    rx_half();
    rx_skips();
    rx_fill();
    tx_coded();
    tx_invert();
    tx_bypass();
    tx_half();
    tx_eight();
    complete_run();
  end
endmodule
`default_nettype wire
